// ==== rscd_cfg.svh ====
/*
 * Constants for the reset strap configuration decoder: strap field
 * positions, host-port codes, address defaults and identity defaults.
 * Assumes it is included by bare name from design files.
 */
`ifndef RSCD_CFG_SVH
`define RSCD_CFG_SVH

// ********************************************************************
// Strap vector layout
// ********************************************************************
`define RSCD_STRAP_W        6
`define RSCD_POS_IF0        0
`define RSCD_POS_IF1        1
`define RSCD_POS_PROF_LO    2
`define RSCD_POS_PROF_HI    4
`define RSCD_POS_TEST       5

// ********************************************************************
// Decode codes
// ********************************************************************
`define RSCD_PROF_NOAUTO    3'h3
`define RSCD_PROF_PROGRAM   3'h0
`define RSCD_HOST_11        2'h3
`define RSCD_HOST_10        2'h2
`define RSCD_ADDR_UPPER     5'h1D
`define RSCD_STRAP_RST      6'h00

// ********************************************************************
// Identity defaults (arbitrary values)
// ********************************************************************
`define RSCD_PART_ID_DEF    12'h5A_5
`define RSCD_REV_DEF        4'h1

// ********************************************************************
// Boot sequence timing
// ********************************************************************
`define RSCD_BOOT_CYCLES    16'h0040

`endif

// ==== rscd_pkg.sv ====
/*
 * Types of the reset strap configuration decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rscd_pkg;
	// Host interface kinds
	typedef enum logic [1:0] {
		RSCD_IF_I2C      = 2'h0,
		RSCD_IF_SPI_SLV  = 2'h1,
		RSCD_IF_SPI_MST  = 2'h3,
		RSCD_IF_PROGRAM  = 2'h2
	} rscd_if_t;

	// Boot controller states, Gray along the path
	typedef enum logic [1:0] {
		RSCD_BT_IDLE = 2'h0,
		RSCD_BT_RUN  = 2'h1,
		RSCD_BT_DONE = 2'h3,
		RSCD_BT_SKIP = 2'h2
	} rscd_boot_t;
endpackage

// ==== rscd_boot_seq.sv ====
/*
 * Boot sequencer: runs the auto-configuration after strap capture on a
 * one-cycle ring oscillator enable and raises a done flag.
 * Assumes i_osc_tick is a same-domain enable pulse.
 */
`timescale 1ns/1ns
`include "rscd_cfg.svh"

module rscd_boot_seq #(
	parameter logic [15:0] BOOT_CYCLES = `RSCD_BOOT_CYCLES  // Ticks per boot
) (
	input  wire logic i_ref_clk,   // System clock
	input  wire logic i_sys_rst,   // Sync reset, high
	input  wire logic i_start,     // Start pulse after capture
	input  wire logic i_skip,      // Skip auto-configuration
	input  wire logic i_osc_tick,  // Ring oscillator enable
	output logic      o_busy,      // Auto-configuration active
	output logic      o_done       // Done flag, sticky
);
	// ****************************************************************
	// State
	// ****************************************************************
	rscd_pkg::rscd_boot_t state_reg, state_next;  // Sequencer state
	logic [15:0]          cnt_reg, cnt_next;      // Tick counter

	// Next state; counting only on oscillator ticks
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			rscd_pkg::RSCD_BT_IDLE: begin
				if (i_start && i_skip) begin
					state_next = rscd_pkg::RSCD_BT_SKIP;  // RULE4
				end else if (i_start) begin
					state_next = rscd_pkg::RSCD_BT_RUN;
					cnt_next   = 16'h0000;
				end
			end
			rscd_pkg::RSCD_BT_RUN: begin
				if (i_osc_tick) begin  // RULE13
					if (cnt_reg == BOOT_CYCLES - 16'h0001) begin
						state_next = rscd_pkg::RSCD_BT_DONE;
					end else begin
						cnt_next = cnt_reg + 16'h0001;
					end
				end
			end
			rscd_pkg::RSCD_BT_DONE: state_next = rscd_pkg::RSCD_BT_DONE;
			rscd_pkg::RSCD_BT_SKIP: state_next = rscd_pkg::RSCD_BT_SKIP;
			default:                state_next = rscd_pkg::RSCD_BT_IDLE;
		endcase
	end

	// Registers only
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_reg <= rscd_pkg::RSCD_BT_IDLE;
			cnt_reg   <= 16'h0000;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// Skipped boot still counts as complete
	assign o_busy = (state_reg == rscd_pkg::RSCD_BT_RUN);
	assign o_done = (state_reg == rscd_pkg::RSCD_BT_DONE) ||
	                (state_reg == rscd_pkg::RSCD_BT_SKIP);  // RULE13
endmodule // rscd_boot_seq

// ==== rscd_strap_decoder.sv ====
/*
 * Reset strap configuration decoder: captures six straps at release of
 * the active-low reset pin, decodes host mode, address and boot source,
 * sequences boot and hands the pins over to their run roles.
 * Assumes i_sys_rst is a power-on reset of the decoder's own clock and
 * that all pin inputs are asynchronous to i_ref_clk.
 */
`timescale 1ns/1ns
`include "rscd_cfg.svh"

// Functional notes
// RULE1 - Latch six straps at reset pin rise
// RULE2 - After release, pins take run roles
// RULE3 - Test strap high selects factory test mode
// RULE4 - Test with profile 011 skips auto-configuration
// RULE5 - Internal variant 1/000/11 enables EEPROM programming
// RULE6 - External variant: I2C addresses or SPI slave
// RULE7 - External variant 11: SPI master then slave; the code keeps o_host_if at SPI master after boot
// RULE8 - Internal variant: I2C low bits equal strap
// RULE9 - Profile strap picks configuration 0 to 7
// RULE10 - Address register write overrides strap default
// RULE11 - Chip select drives EEPROM during boot only
// RULE12 - Read-only 12-bit ID and 4-bit revision
// RULE13 - Boot runs on ring oscillator, raises done
// RULE14 - Register port independent of ring oscillator
// RULE15 - Decoded mode fixed until next reset
module rscd_strap_decoder #(
	parameter logic        INT_EEPROM  = 1'b0,               // Internal EEPROM variant
	parameter logic [11:0] PART_ID     = `RSCD_PART_ID_DEF,  // Arbitrary ID value
	parameter logic [3:0]  REVISION    = `RSCD_REV_DEF,      // Arbitrary revision
	parameter logic [15:0] BOOT_CYCLES = `RSCD_BOOT_CYCLES   // Boot length in ticks
) (
	input  wire logic        i_ref_clk,              // 100 MHz clock
	input  wire logic        i_sys_rst,              // Sync reset, high
	input  wire logic        i_active_low_reset_pin, // Reset pin, low active
	input  wire logic [5:0]  i_strap_pins,           // TEST,PROF[2:0],HOST[1:0]
	input  wire logic        i_osc_tick,             // Ring oscillator enable
	input  wire logic        i_addr_wr,              // Address register write
	input  wire logic [6:0]  i_addr_wdata,           // New bus address
	input  wire logic        i_gpio_out,             // Run value for gpio pins
	input  wire logic        i_spi_miso,             // Run value for data-out
	input  wire logic        i_spi_cs_bar,           // Boot master chip select
	output logic [5:0]       o_strap_capture_reg,    // Captured strap levels
	output logic             o_factory_test,         // Test mode active
	output logic [2:0]       o_test_select,          // Which test mode
	output logic             o_skip_autocfg,         // No auto-configuration
	output logic             o_eeprom_program,       // Programmer access mode
	output logic [1:0]       o_host_if,              // Host interface kind
	output logic             o_boot_ext_eeprom,      // Boot from ext EEPROM
	output logic [2:0]       o_config_index,         // Configuration number
	output logic [6:0]       o_bus_address_reg,      // I2C slave address
	output logic [15:0]      o_part_code_reg_a,      // 12-bit ID, top 4 bits zero
	output logic [15:0]      o_part_code_reg_b,      // Revision, top 12 bits zero
	output logic             o_boot_done_flag,       // Boot complete
	output logic             o_chip_select_bar,      // Chip select pin level
	output logic             o_chip_select_oe,       // Chip select pin enable
	output logic             o_strap_pins_run        // Pins in run role
);
	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic       rst_pin_s1_reg, rst_pin_s2_reg, rst_pin_d_reg;  // Reset pin sync
	logic [5:0] strap_s1_reg, strap_s2_reg;                     // Strap sync

	// Two flops per pin, plus one for edge detect off the second
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			rst_pin_s1_reg <= 1'b0;
			rst_pin_s2_reg <= 1'b0;
			rst_pin_d_reg  <= 1'b0;
			strap_s1_reg   <= `RSCD_STRAP_RST;
			strap_s2_reg   <= `RSCD_STRAP_RST;
		end else begin
			rst_pin_s1_reg <= i_active_low_reset_pin;
			rst_pin_s2_reg <= rst_pin_s1_reg;
			rst_pin_d_reg  <= rst_pin_s2_reg;
			strap_s1_reg   <= i_strap_pins;
			strap_s2_reg   <= strap_s1_reg;
		end
	end

	logic rise; // Release of the reset pin
	assign rise = rst_pin_s2_reg && !rst_pin_d_reg;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// Host interface kind from host, test and profile straps and variant
	function automatic rscd_pkg::rscd_if_t host_kind(input logic [1:0] h,
	                                                 input logic t,
	                                                 input logic [2:0] p);
		host_kind = rscd_pkg::RSCD_IF_I2C;
		if (INT_EEPROM) begin
			if (t && p == `RSCD_PROF_PROGRAM && h == `RSCD_HOST_11)
				host_kind = rscd_pkg::RSCD_IF_PROGRAM;  // RULE5
			else if (h == `RSCD_HOST_11)
				host_kind = rscd_pkg::RSCD_IF_SPI_SLV;  // RULE8
		end else begin
			if (h == `RSCD_HOST_11)
				host_kind = rscd_pkg::RSCD_IF_SPI_MST;  // RULE7
			else if (h == `RSCD_HOST_10)
				host_kind = rscd_pkg::RSCD_IF_SPI_SLV;  // RULE6
		end
	endfunction

	// ****************************************************************
	// Captured configuration
	// ****************************************************************
	logic [5:0]        cap_reg, cap_next;      // Strap capture
	logic              run_reg, run_next;      // Run role reached
	logic [6:0]        addr_reg, addr_next;    // Bus address
	rscd_pkg::rscd_if_t if_reg, if_next;       // Host interface kind
	logic              start_reg, start_next;  // Boot start pulse

	logic [1:0] s_host; // Synced host strap
	logic [2:0] s_prof; // Synced profile strap
	logic       s_test; // Synced test strap
	assign s_host = strap_s2_reg[`RSCD_POS_IF1:`RSCD_POS_IF0];
	assign s_prof = strap_s2_reg[`RSCD_POS_PROF_HI:`RSCD_POS_PROF_LO];
	assign s_test = strap_s2_reg[`RSCD_POS_TEST];

	// Capture once; later strap motion ignored until next reset
	always_comb begin
		cap_next   = cap_reg;
		run_next   = run_reg;
		addr_next  = addr_reg;
		if_next    = if_reg;
		start_next = 1'b0;
		if (rise && !run_reg) begin
			cap_next   = strap_s2_reg;                      // RULE1
			run_next   = 1'b1;                              // RULE2
			if_next    = host_kind(s_host, s_test, s_prof); // RULE15
			addr_next  = {`RSCD_ADDR_UPPER, s_host};        // RULE6 RULE8
			start_next = 1'b1;
		end else if (i_addr_wr) begin
			addr_next = i_addr_wdata;                       // RULE10
		end
		if (!rst_pin_s2_reg) begin
			run_next = 1'b0;  // Pin held low re-arms capture
		end
	end

	// Registers only
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			cap_reg   <= `RSCD_STRAP_RST;
			run_reg   <= 1'b0;
			addr_reg  <= {`RSCD_ADDR_UPPER, 2'h0};
			if_reg    <= rscd_pkg::RSCD_IF_I2C;
			start_reg <= 1'b0;
		end else begin
			cap_reg   <= cap_next;
			run_reg   <= run_next;
			addr_reg  <= addr_next;
			if_reg    <= if_next;
			start_reg <= start_next;
		end
	end

	// ****************************************************************
	// Boot sequencer
	// ****************************************************************
	logic c_test, c_skip, boot_busy, boot_done; // Decoded boot terms
	assign c_test = cap_reg[`RSCD_POS_TEST];
	assign c_skip = c_test &&
	    cap_reg[`RSCD_POS_PROF_HI:`RSCD_POS_PROF_LO] == `RSCD_PROF_NOAUTO;

	// Oscillator ticks only pace boot, never the register side (RULE14)
	rscd_boot_seq #(
		.BOOT_CYCLES (BOOT_CYCLES)
	) u_boot (
		.i_ref_clk  (i_ref_clk),
		.i_sys_rst  (i_sys_rst || !rst_pin_s2_reg),
		.i_start    (start_reg),
		.i_skip     (c_skip),
		.i_osc_tick (i_osc_tick),  // RULE14
		.o_busy     (boot_busy),
		.o_done     (boot_done)
	);

	// ****************************************************************
	// Output registers
	// ****************************************************************
	logic cs_bar_next, cs_oe_next; // Chip select pin drive

	// Chip select driven only while the boot master is reading
	always_comb begin
		cs_oe_next  = 1'b0;
		cs_bar_next = 1'b1;
		if (boot_busy && if_reg == rscd_pkg::RSCD_IF_SPI_MST) begin
			cs_oe_next  = 1'b1;          // RULE11
			cs_bar_next = i_spi_cs_bar;  // RULE11
		end
	end

	// Every top output comes from a flop
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_strap_capture_reg <= `RSCD_STRAP_RST;
			o_factory_test      <= 1'b0;
			o_test_select       <= 3'h0;
			o_skip_autocfg      <= 1'b0;
			o_eeprom_program    <= 1'b0;
			o_host_if           <= 2'h0;
			o_boot_ext_eeprom   <= 1'b0;
			o_config_index      <= 3'h0;
			o_bus_address_reg   <= 7'h00;
			o_part_code_reg_a   <= 16'h0000;
			o_part_code_reg_b   <= 16'h0000;
			o_boot_done_flag    <= 1'b0;
			o_chip_select_bar   <= 1'b1;
			o_chip_select_oe    <= 1'b0;
			o_strap_pins_run    <= 1'b0;
		end else begin
			o_strap_capture_reg <= cap_reg;                                      // RULE1
			o_factory_test      <= c_test;                                       // RULE3
			o_test_select       <= c_test ?
			    cap_reg[`RSCD_POS_PROF_HI:`RSCD_POS_PROF_LO] : 3'h0;             // RULE3
			o_skip_autocfg      <= c_skip;                                       // RULE4
			o_eeprom_program    <= (if_reg == rscd_pkg::RSCD_IF_PROGRAM);        // RULE5
			o_host_if           <= if_reg;                                       // RULE15
			o_boot_ext_eeprom   <= (if_reg == rscd_pkg::RSCD_IF_SPI_MST);        // RULE7
			o_config_index      <= cap_reg[`RSCD_POS_PROF_HI:`RSCD_POS_PROF_LO]; // RULE9
			o_bus_address_reg   <= addr_reg;                                     // RULE10
			o_part_code_reg_a   <= {4'h0, PART_ID};                              // RULE12
			o_part_code_reg_b   <= {12'h000, REVISION};                          // RULE12
			o_boot_done_flag    <= boot_done;                                    // RULE13
			o_chip_select_bar   <= cs_bar_next;
			o_chip_select_oe    <= cs_oe_next;
			o_strap_pins_run    <= run_reg;                                      // RULE2
		end
	end
	// Unused run-role data inputs are routed by the pad ring via o_strap_pins_run
	logic unused_run; // Absorbs pad-side values
	assign unused_run = i_gpio_out ^ i_spi_miso;
endmodule // rscd_strap_decoder

// ==== rscd_strap_checker.sv ====
/* Checker for the strap decoder: decode, hold, address and boot relations.
 * Assumes one clock, synchronous reset, bound to every decoder instance. */
`timescale 1ns/1ns
module rscd_strap_checker #(
	parameter logic [11:0] PART_ID  = 12'h000, // Handed on by bind
	parameter logic [3:0]  REVISION = 4'h0     // Handed on by bind
) (
	input wire logic        i_ref_clk,           // Clock
	input wire logic        i_sys_rst,           // Sync reset
	input wire logic        i_addr_wr,           // Address write
	input wire logic [6:0]  i_addr_wdata,        // Address value
	input wire logic [5:0]  o_strap_capture_reg, // Captured straps
	input wire logic        o_factory_test,      // Test mode
	input wire logic [2:0]  o_test_select,       // Test choice
	input wire logic        o_skip_autocfg,      // No autoconfig
	input wire logic [1:0]  o_host_if,           // Host kind
	input wire logic        o_boot_ext_eeprom,   // Ext boot
	input wire logic [2:0]  o_config_index,      // Config number
	input wire logic [6:0]  o_bus_address_reg,   // Bus address
	input wire logic [15:0] o_part_code_reg_a,   // ID word
	input wire logic [15:0] o_part_code_reg_b,   // Revision word
	input wire logic        o_boot_done_flag,    // Done
	input wire logic        o_chip_select_oe,    // Select enable
	input wire logic        o_strap_pins_run     // Run role
);
	// ********
	// Helper: last written address
	// ********
	logic [6:0] wdata_reg;  // Held so late checks see it
	logic [6:0] wdata_next; // Next value
	// Load on each write
	always_comb begin
		wdata_next = i_addr_wr ? i_addr_wdata : wdata_reg;
	end
	// Register only
	always_ff @(posedge i_ref_clk) begin
		wdata_reg <= wdata_next;
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	test_sel_a: assert property (!o_factory_test |-> o_test_select == 3'h0)
		else $error("test select set outside test mode");
	skip_decode_a: assert property (o_skip_autocfg |-> o_factory_test && o_test_select == 3'h3)
		else $error("skip without test profile three");
	boot_src_a: assert property (o_boot_ext_eeprom == (o_host_if == 2'h3))
		else $error("boot source disagrees with host mode");
	config_index_a: assert property (o_strap_pins_run |-> o_config_index == o_strap_capture_reg[4:2])
		else $error("config index not profile strap");
	decode_hold_a: assert property (o_strap_pins_run && $past(o_strap_pins_run) |-> $stable(o_strap_capture_reg) && $stable(o_host_if))
		else $error("decode changed while running");
	ident_words_a: assert property (o_strap_pins_run |-> o_part_code_reg_a == {4'h0, PART_ID} && o_part_code_reg_b == {12'h000, REVISION})
		else $error("identity words wrong");
	select_idle_a: assert property (!o_boot_ext_eeprom || o_boot_done_flag |-> !o_chip_select_oe)
		else $error("select driven outside master boot");
	default_addr_a: assert property ($rose(o_strap_pins_run) |-> o_bus_address_reg == {5'h1D, o_strap_capture_reg[1:0]})
		else $error("default address wrong");
	addr_write_a: assert property (i_addr_wr && o_strap_pins_run |-> ##[1:2] o_bus_address_reg == wdata_reg)
		else $error("address write not taken");
	skip_done_a: assert property ($rose(o_strap_pins_run) && o_skip_autocfg |-> ##[1:4] o_boot_done_flag)
		else $error("skipped boot not done quickly");
	boot_length_a: assert property ($rose(o_strap_pins_run) && !o_skip_autocfg |-> !o_boot_done_flag [*4])
		else $error("boot done too early");
endmodule // rscd_strap_checker

bind rscd_strap_decoder rscd_strap_checker #(.PART_ID(PART_ID), .REVISION(REVISION)) u_chk (
	.i_ref_clk, .i_sys_rst, .i_addr_wr, .i_addr_wdata, .o_strap_capture_reg, .o_factory_test,
	.o_test_select, .o_skip_autocfg, .o_host_if, .o_boot_ext_eeprom, .o_config_index,
	.o_bus_address_reg, .o_part_code_reg_a, .o_part_code_reg_b, .o_boot_done_flag,
	.o_chip_select_oe, .o_strap_pins_run);

// ==== rscd_board_model.sv ====
/* Board model: strap resistors, ring oscillator ticks, boot select level.
 * Assumes the bench drives the reset pin and the resistor pattern. */
`timescale 1ns/1ns
module rscd_board_model (
	input  wire logic       i_ref_clk,    // Clock
	input  wire logic       i_pin_level,  // Reset pin level
	input  wire logic [5:0] i_strap_set,  // Resistor pattern
	output logic      [5:0] o_strap_pins, // Pad levels
	output logic            o_osc_tick,   // Oscillator enable
	output logic            o_cs_bar      // Boot select level
);
	logic [1:0] div_reg;  // Oscillator divider, slow on purpose
	logic [2:0] hold_reg; // Strap hold time after release
	logic       pin_q;    // Pin seen at the edge
	initial begin
		o_strap_pins = 6'h00;
		o_osc_tick = 1'b0;
		o_cs_bar = 1'b1;
		div_reg = 2'h0;
		hold_reg = 3'h0;
	end
	// All output changes land just after the edge
	always @(posedge i_ref_clk) begin
		pin_q = i_pin_level;
		#1;
		div_reg = (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
		o_osc_tick = (div_reg == 2'h0);
		o_cs_bar = div_reg[0];
		if (!pin_q) begin
			hold_reg = 3'h0;
			o_strap_pins = i_strap_set;
		end else if (hold_reg != 3'h4) begin
			hold_reg = hold_reg + 3'h1;
		end else begin
			o_strap_pins = ~o_strap_pins;
		end
	end
endmodule // rscd_board_model

// ==== test_rscd_strap_decoder.sv ====
/* Bench: both variants side by side, one strap table, address write.
 * Assumes the board model and the bound checker are compiled first. */
`timescale 1ns/1ns
module test_rscd_strap_decoder;
	logic       clk = 1'b0;    // Clock
	logic       rst = 1'b1;    // Sync reset
	logic       pin = 1'b0;    // Reset pin
	logic       wr = 1'b0;     // Address write
	logic [6:0] wdata = 7'h00; // Address value
	logic [5:0] set = 6'h00;   // Resistor pattern
	logic [5:0] straps;        // Pads
	logic       tick;          // Oscillator enable
	logic       csb;           // Boot select
	logic [5:0] cap [2];       // Per variant outputs
	logic [2:0] tsel [2];
	logic [2:0] idx [2];
	logic [1:0] hif [2];
	logic [6:0] addr [2];
	logic [15:0] ida [2];
	logic [15:0] idb [2];
	logic [1:0] ft, skip, prog, ext, done, run, oe, csel;
	int         failures = 0;
	int         cmp_count = 0;
	logic [5:0] cases [9] = '{6'h00, 6'h15, 6'h1E, 6'h0B, 6'h2C, 6'h23, 6'h39, 6'h04, 6'h12};
	always #5 clk = ~clk;
	rscd_board_model i_board (.i_ref_clk(clk), .i_pin_level(pin), .i_strap_set(set),
		.o_strap_pins(straps), .o_osc_tick(tick), .o_cs_bar(csb));
	// Variant 0 external memory, variant 1 internal
	for (genvar v = 0; v < 2; v++) begin : g_var
		rscd_strap_decoder #(.INT_EEPROM((v == 1) ? 1'b1 : 1'b0), .PART_ID(12'h3C7),
			.REVISION(4'h9), .BOOT_CYCLES(16'h0004)) i_dut (
			.i_ref_clk(clk), .i_sys_rst(rst), .i_active_low_reset_pin(pin),
			.i_strap_pins(straps), .i_osc_tick(tick), .i_addr_wr(wr), .i_addr_wdata(wdata),
			.i_gpio_out(1'b0), .i_spi_miso(1'b0), .i_spi_cs_bar(csb),
			.o_strap_capture_reg(cap[v]), .o_factory_test(ft[v]), .o_test_select(tsel[v]),
			.o_skip_autocfg(skip[v]), .o_eeprom_program(prog[v]), .o_host_if(hif[v]),
			.o_boot_ext_eeprom(ext[v]), .o_config_index(idx[v]), .o_bus_address_reg(addr[v]),
			.o_part_code_reg_a(ida[v]), .o_part_code_reg_b(idb[v]),
			.o_boot_done_flag(done[v]), .o_chip_select_bar(csel[v]), .o_chip_select_oe(oe[v]),
			.o_strap_pins_run(run[v]));
	end
	// Inputs move just after the edge
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [1:0] exp_if(input int v, input logic [1:0] h, input logic pr);
		if (h != 2'h3) return (v == 0 && h == 2'h2) ? 2'h1 : 2'h0;
		if (v == 0) return 2'h3;
		return pr ? 2'h2 : 2'h1;
	endfunction
	// One reset pin cycle with a strap pattern
	task automatic boot(input logic [5:0] s);
		logic       t;
		logic [2:0] p;
		logic [1:0] h;
		int         n;
		t = s[5];
		p = s[4:2];
		h = s[1:0];
		pin = 1'b0;
		set = s;
		repeat (6) step();
		chk("run low", 16'(run), 16'h0000);
		pin = 1'b1;
		repeat (14) step();
		for (int v = 0; v < 2; v++) begin
			chk("capture", 16'(cap[v]), 16'(s));
			chk("test", 16'(ft[v]), 16'(t));
			chk("test sel", 16'(tsel[v]), 16'(t ? p : 3'h0));
			chk("skip", 16'(skip[v]), 16'(t && p == 3'h3));
			chk("program", 16'(prog[v]), 16'(v == 1 && t && p == 3'h0 && h == 2'h3));
			chk("host if", 16'(hif[v]), 16'(exp_if(v, h, t && p == 3'h0)));
			chk("ext boot", 16'(ext[v]), 16'(v == 0 && h == 2'h3));
			chk("index", 16'(idx[v]), 16'(p));
			chk("address", 16'(addr[v]), 16'({5'h1D, h}));
			chk("id a", ida[v], 16'h03C7);
			chk("id b", idb[v], 16'h0009);
			chk("run", 16'(run[v]), 16'h0001);
			// Four ticks of three cycles keep a full boot busy past this point
			chk("done early", 16'(done[v]), 16'(t && p == 3'h3));
			chk("select drive", 16'(oe[v]), 16'(v == 0 && h == 2'h3 && !(t && p == 3'h3)));
		end
		n = 0;
		while (done !== 2'b11 && n < 300) begin
			step();
			n++;
		end
		if (n == 300) begin
			failures++;
			complete_run();
		end else begin
			chk("select oe", 16'(oe), 16'h0000);
			chk("select bar", 16'(csel), 16'h0003);
		end
	endtask
	initial begin
		repeat (20) step();
		rst = 1'b0;
		step();
		foreach (cases[i]) boot(cases[i]);
		wdata = 7'h2A;
		wr = 1'b1;
		step();
		wr = 1'b0;
		repeat (3) step();
		chk("addr write 0", 16'(addr[0]), 16'h002A);
		chk("addr write 1", 16'(addr[1]), 16'h002A);
		complete_run();
	end
endmodule // test_rscd_strap_decoder
